// ---- src/ssap_map.svh ----
`ifndef SSAP_MAP_SVH
`define SSAP_MAP_SVH

// ----------------------------------------
// Bit positions within a channel half
// ----------------------------------------
`define SSAP_LJ_START  6'h00
`define SSAP_DLY_START 6'h01
`define SSAP_RJ_START  6'h10
`define SSAP_POS_MAX   6'h3f

// ----------------------------------------
// Synchroniser fill count before edges count
// ----------------------------------------
`define SSAP_SYNC_FULL 2'h3

// ----------------------------------------
// Default word widths
// ----------------------------------------
`define SSAP_IN_WIDTH  16
`define SSAP_OUT_WIDTH 24

`endif

// ---- src/ssap_pkg.sv ----
package ssap_pkg;

	// ----------------------------------------
	// Framing formats, code is {sel_a, sel_b}
	// ----------------------------------------
	typedef enum logic [1:0] {
		ssap_fmt_lj     = 2'b00,
		ssap_fmt_lj_dly = 2'b01,
		ssap_fmt_rj     = 2'b10,
		ssap_fmt_ws     = 2'b11
	} ssap_fmt_t;

endpackage : ssap_pkg

// ---- src/ssap_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssap_map.svh"

module ssap_sync #(
	parameter int N = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic [N-1:0] pin,
	output logic      [N-1:0] level,
	output logic      [N-1:0] rise,
	output logic      [N-1:0] fall
);
	logic [N-1:0] meta;
	logic [N-1:0] prev;
	logic [1:0]   fill;

	// First stage is read only by the second
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			meta  <= '0;
			level <= '0;
			prev  <= '0;
		end else begin
			meta  <= pin;
			level <= meta;
			prev  <= level;
		end
	end

	// Edges held off until all three stages carry the pin, so a pin
	// resting high gives no false edge after reset
	always_ff @(posedge mclk) begin
		if (!rst_b)
			fill <= '0;
		else if (fill != `SSAP_SYNC_FULL)
			fill <= fill + 2'h1;
	end

	assign rise = (fill == `SSAP_SYNC_FULL) ? (level & ~prev) : '0;
	assign fall = (fill == `SSAP_SYNC_FULL) ? (~level & prev) : '0;

endmodule : ssap_sync

`default_nettype wire

// ---- src/ssap_rx.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ssap_map.svh"

module ssap_rx
	import ssap_pkg::*;
#(
	parameter int W = `SSAP_IN_WIDTH
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic         evt,
	input  wire logic         lr,
	input  wire logic         ws,
	input  wire logic         din,
	input  wire ssap_fmt_t    fmt,
	output logic      [W-1:0] left,
	output logic      [W-1:0] right,
	output logic              valid
);
	localparam int CW = $clog2(W + 1);

	logic          lr_at;
	logic          ws_at;
	logic [5:0]    pos;
	logic [5:0]    next_pos;
	logic          going;
	logic [CW-1:0] cnt;
	logic [W-1:0]  sh;
	logic          turn;
	logic          ws_up;
	logic          start_now;

	assign turn  = evt && (lr != lr_at);
	assign ws_up = evt && ws && !ws_at;

	always_comb begin
		next_pos = turn ? `SSAP_LJ_START : pos;
		if (!turn && pos != `SSAP_POS_MAX)
			next_pos = pos + 6'h01;
	end

	always_comb begin
		unique case (fmt)
			ssap_fmt_lj:     start_now = turn;
			ssap_fmt_lj_dly: start_now = evt && next_pos == `SSAP_DLY_START;
			ssap_fmt_rj:     start_now = evt && next_pos == `SSAP_RJ_START;
			ssap_fmt_ws:     start_now = ws_up;
		endcase
	end

	// ----------------------------------------
	// Bit capture, MSB first
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			lr_at <= 1'b0;
			ws_at <= 1'b0;
			pos   <= `SSAP_LJ_START;
			going <= 1'b0;
			cnt   <= '0;
			sh    <= '0;
		end else if (evt) begin
			lr_at <= lr;
			ws_at <= ws;
			pos   <= next_pos;
			if (start_now) begin
				going <= 1'b1;
				cnt   <= CW'(1);
				sh    <= {{(W-1){1'b0}}, din};
			end else if (turn) begin
				going <= 1'b0;
				cnt   <= '0;
			end else if (going && cnt < CW'(W)) begin
				cnt <= cnt + CW'(1);
				sh  <= {sh[W-2:0], din};
			end
		end
	end

	// ----------------------------------------
	// Word close at channel change
	// ----------------------------------------
	// Short words are zero-filled in the LSBs
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			left  <= '0;
			right <= '0;
			valid <= 1'b0;
		end else begin
			valid <= 1'b0;
			if (turn && going) begin
				if (lr_at) begin
					left <= sh << (CW'(W) - cnt);
				end else begin
					right <= sh << (CW'(W) - cnt);
					valid <= 1'b1;
				end
			end
		end
	end

	a_lj_msb: assert property (@(posedge mclk) disable iff (!rst_b)
		(turn && fmt == ssap_fmt_lj) |-> start_now)
		else $error("msb not taken at channel change");
	a_dly_msb: assert property (@(posedge mclk) disable iff (!rst_b)
		(start_now && fmt == ssap_fmt_lj_dly) |-> (!turn && pos == `SSAP_LJ_START))
		else $error("delayed msb not one bit after change");
	a_rj_msb: assert property (@(posedge mclk) disable iff (!rst_b)
		(start_now && fmt == ssap_fmt_rj) |-> pos == `SSAP_RJ_START - 6'h01)
		else $error("right-justified msb at wrong position");
	a_ws_msb: assert property (@(posedge mclk) disable iff (!rst_b)
		(start_now && fmt == ssap_fmt_ws) |-> (ws && !ws_at))
		else $error("strobe-mode word not started at strobe rise");

endmodule : ssap_rx

`default_nettype wire

// ---- src/ssap_ports.sv ----
// What this block does
// - Output sends two channels MSB first, 4-24 bits.
// - Output tolerates gated or burst bit clock.
// - Word strobe acts at rising edge only.
// - Input samples on edge chosen by polarity.
// - Input left-justified, no delay or one-bit delay.
// - Input right-justified MSB sixteen bits after change.
// - Input strobe mode starts word at strobe rise.
// - Output framing follows its format select code.
// - Output strobe mode starts word at strobe rise.
// - Output changes on launch edge per polarity.
// - Mute forces every output bit to zero.
`timescale 1ns/1ps
`default_nettype none
`include "ssap_map.svh"

module ssap_ports
	import ssap_pkg::*;
#(
	parameter int IN_W  = `SSAP_IN_WIDTH,
	parameter int OUT_W = `SSAP_OUT_WIDTH
) (
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic             in_bit_clock,
	input  wire logic             in_channel_clock,
	input  wire logic             in_word_strobe,
	input  wire logic             in_data,
	input  wire logic             in_edge_polarity,
	input  wire logic             in_format_sel_a,
	input  wire logic             in_format_sel_b,
	output logic      [IN_W-1:0]  in_left,
	output logic      [IN_W-1:0]  in_right,
	output logic                  in_valid,
	input  wire logic             out_bit_clock,
	input  wire logic             out_channel_clock,
	input  wire logic             out_word_strobe,
	input  wire logic             out_edge_polarity,
	input  wire logic             out_format_sel_a,
	input  wire logic             out_format_sel_b,
	input  wire logic             mute,
	input  wire logic [OUT_W-1:0] out_left,
	input  wire logic [OUT_W-1:0] out_right,
	output logic                  out_take,
	output logic                  out_data
);
	localparam int TCW = $clog2(OUT_W + 1);

	logic             in_bck_rise;
	logic             in_bck_fall;
	logic             in_lr;
	logic             in_ws;
	logic             in_din;
	logic [2:0]       in_cfg;
	logic             in_smp;
	logic             out_bck;
	logic             out_bck_rise;
	logic             out_bck_fall;
	logic             out_lr;
	logic             out_ws;
	logic [2:0]       out_cfg;
	logic             mute_s;
	ssap_fmt_t        tx_fmt;
	logic             tx_launch;
	logic             tx_lr;
	logic             tx_ws;
	logic [5:0]       tx_pos;
	logic [5:0]       tx_next_pos;
	logic             tx_turn;
	logic             tx_ws_up;
	logic             tx_start;
	logic             tx_drive;
	logic [TCW-1:0]   tx_cnt;
	logic [OUT_W-1:0] tx_sh;
	logic [OUT_W-1:0] tx_hold;
	logic [OUT_W-1:0] tx_word;
	logic             tx_bit;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Clocks are sampled, not used as clocks: bit clock must stay
	// well below a sixth of mclk for the launch to meet capture
	ssap_sync #(.N(1)) u_in_bck (
		.mclk  (mclk),
		.rst_b (rst_b),
		.pin   (in_bit_clock),
		.level (),
		.rise  (in_bck_rise),
		.fall  (in_bck_fall)
	);
	ssap_sync #(.N(1)) u_in_lr (
		.mclk  (mclk),
		.rst_b (rst_b),
		.pin   (in_channel_clock),
		.level (in_lr),
		.rise  (),
		.fall  ()
	);
	ssap_sync #(.N(1)) u_in_ws (
		.mclk  (mclk),
		.rst_b (rst_b),
		.pin   (in_word_strobe),
		.level (in_ws),
		.rise  (),
		.fall  ()
	);
	ssap_sync #(.N(1)) u_in_din (
		.mclk  (mclk),
		.rst_b (rst_b),
		.pin   (in_data),
		.level (in_din),
		.rise  (),
		.fall  ()
	);
	ssap_sync #(.N(3)) u_in_cfg (
		.mclk  (mclk),
		.rst_b (rst_b),
		.pin   ({in_edge_polarity, in_format_sel_a, in_format_sel_b}),
		.level (in_cfg),
		.rise  (),
		.fall  ()
	);
	ssap_sync #(.N(1)) u_out_bck (
		.mclk  (mclk),
		.rst_b (rst_b),
		.pin   (out_bit_clock),
		.level (out_bck),
		.rise  (out_bck_rise),
		.fall  (out_bck_fall)
	);
	ssap_sync #(.N(1)) u_out_lr (
		.mclk  (mclk),
		.rst_b (rst_b),
		.pin   (out_channel_clock),
		.level (out_lr),
		.rise  (),
		.fall  ()
	);
	ssap_sync #(.N(1)) u_out_ws (
		.mclk  (mclk),
		.rst_b (rst_b),
		.pin   (out_word_strobe),
		.level (out_ws),
		.rise  (),
		.fall  ()
	);
	ssap_sync #(.N(3)) u_out_cfg (
		.mclk  (mclk),
		.rst_b (rst_b),
		.pin   ({out_edge_polarity, out_format_sel_a, out_format_sel_b}),
		.level (out_cfg),
		.rise  (),
		.fall  ()
	);
	ssap_sync #(.N(1)) u_mute (
		.mclk  (mclk),
		.rst_b (rst_b),
		.pin   (mute),
		.level (mute_s),
		.rise  (),
		.fall  ()
	);

	// ----------------------------------------
	// Input port
	// ----------------------------------------
	// Data passes the same two stages as its clock, so it is
	// sampled as it stood at the real edge
	assign in_smp = in_cfg[2] ? in_bck_fall : in_bck_rise;

	ssap_rx #(.W(IN_W)) u_rx (
		.mclk  (mclk),
		.rst_b (rst_b),
		.evt   (in_smp),
		.lr    (in_lr),
		.ws    (in_ws),
		.din   (in_din),
		.fmt   (ssap_fmt_t'(in_cfg[1:0])),
		.left  (in_left),
		.right (in_right),
		.valid (in_valid)
	);

	// ----------------------------------------
	// Output port framing
	// ----------------------------------------
	assign tx_fmt    = ssap_fmt_t'(out_cfg[1:0]);
	assign tx_launch = out_cfg[2] ? out_bck_rise : out_bck_fall;
	assign tx_turn   = tx_launch && (out_lr != tx_lr);
	assign tx_ws_up  = tx_launch && out_ws && !tx_ws;

	always_comb begin
		tx_next_pos = tx_turn ? `SSAP_LJ_START : tx_pos;
		if (!tx_turn && tx_pos != `SSAP_POS_MAX)
			tx_next_pos = tx_pos + 6'h01;
	end

	always_comb begin
		unique case (tx_fmt)
			ssap_fmt_lj:     tx_start = tx_turn;
			ssap_fmt_lj_dly: tx_start = tx_launch && tx_next_pos == `SSAP_DLY_START;
			ssap_fmt_rj:     tx_start = tx_launch && tx_next_pos == `SSAP_RJ_START;
			ssap_fmt_ws:     tx_start = tx_ws_up;
		endcase
	end

	// New channel word is picked at the change, left from the user
	// port, right from the copy taken with it
	always_comb begin
		tx_word = tx_sh;
		if (tx_turn)
			tx_word = out_lr ? out_left : tx_hold;
	end

	always_comb begin
		tx_bit = 1'b0;
		if (tx_start)
			tx_bit = tx_word[OUT_W-1];
		else if (tx_drive && !tx_turn && tx_cnt < TCW'(OUT_W))
			tx_bit = tx_sh[OUT_W-1];
	end

	// ----------------------------------------
	// Output shifter
	// ----------------------------------------
	// Advances only on launch edges, so a stopped clock just holds
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tx_lr    <= 1'b0;
			tx_ws    <= 1'b0;
			tx_pos   <= `SSAP_LJ_START;
			tx_drive <= 1'b0;
			tx_cnt   <= '0;
			tx_sh    <= '0;
		end else if (tx_launch) begin
			tx_lr  <= out_lr;
			tx_ws  <= out_ws;
			tx_pos <= tx_next_pos;
			if (tx_start) begin
				tx_drive <= 1'b1;
				tx_cnt   <= TCW'(1);
				tx_sh    <= tx_word << 1;
			end else if (tx_turn) begin
				tx_drive <= 1'b0;
				tx_cnt   <= '0;
				tx_sh    <= tx_word;
			end else if (tx_drive && tx_cnt < TCW'(OUT_W)) begin
				tx_cnt <= tx_cnt + TCW'(1);
				tx_sh  <= tx_sh << 1;
			end else begin
				tx_drive <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			tx_hold  <= '0;
			out_take <= 1'b0;
		end else begin
			out_take <= tx_turn && out_lr;
			if (tx_turn && out_lr)
				tx_hold <= out_right;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_b)
			out_data <= 1'b0;
		else if (mute_s)
			out_data <= 1'b0;
		else if (tx_launch)
			out_data <= tx_bit;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_sample_edge: assert property (@(posedge mclk) disable iff (!rst_b)
		in_smp |-> (in_cfg[2] ? !$past(in_bck_fall) : !$past(in_bck_rise)))
		else $error("input sampled twice on one edge");
	a_launch_edge: assert property (@(posedge mclk) disable iff (!rst_b)
		tx_launch |-> (out_cfg[2] ? out_bck : !out_bck))
		else $error("output launched on wrong edge");
	a_mute_zero: assert property (@(posedge mclk) disable iff (!rst_b)
		mute_s |=> !out_data)
		else $error("output not zero while muted");
	a_data_hold: assert property (@(posedge mclk) disable iff (!rst_b)
		$changed(out_data) |-> $past(tx_launch || mute_s))
		else $error("output changed without launch edge");
	a_tx_msb_pos: assert property (@(posedge mclk) disable iff (!rst_b)
		(tx_start && tx_fmt != ssap_fmt_ws) |->
			(tx_fmt == ssap_fmt_lj && tx_turn) ||
			(tx_fmt == ssap_fmt_lj_dly && !tx_turn && tx_pos == `SSAP_LJ_START) ||
			(tx_fmt == ssap_fmt_rj && !tx_turn && tx_pos == `SSAP_RJ_START - 6'h01))
		else $error("output msb at wrong position");
	a_tx_ws_start: assert property (@(posedge mclk) disable iff (!rst_b)
		(tx_launch && tx_fmt == ssap_fmt_ws && out_ws && !tx_ws) |=> tx_drive)
		else $error("strobe rise did not start word");
	a_ws_rise_only: assert property (@(posedge mclk) disable iff (!rst_b)
		(tx_start && tx_fmt == ssap_fmt_ws) |-> (out_ws && !tx_ws))
		else $error("strobe-mode word started without rise");
	a_word_len: assert property (@(posedge mclk) disable iff (!rst_b)
		(tx_launch && tx_drive && !tx_start && tx_cnt == TCW'(OUT_W)) |=> !tx_drive)
		else $error("output word longer than width");

endmodule : ssap_ports

`default_nettype wire

// ---- test/ssap_far_end.sv ----
`timescale 1ns/1ps
`default_nettype none

module ssap_far_end (
	input  wire logic        out_data,
	output logic             bclk,
	output logic             lrclk,
	output logic             wstrb,
	output logic             sdata,
	output logic [23:0]      cap_l,
	output logic [23:0]      cap_r,
	output int               stray
);
	initial begin
		bclk = 1'b1;
		lrclk = 1'b0;
		wstrb = 1'b0;
		sdata = 1'b0;
		cap_l = '0;
		cap_r = '0;
		stray = 0;
	end

	// ----------------------------------------
	// One frame of 2 x 32 bit periods, left while high
	// ----------------------------------------
	task automatic frame(input logic [1:0] f, input logic p, input logic [15:0] lw,
		input logic [15:0] rw, input int n, input bit gap);
		int s;
		int i;
		s = (f == 2'b00) ? 0 : (f == 2'b01) ? 1 : (f == 2'b10) ? 16 : 3;
		// Bits the port never sends must read as zero, not as an older frame
		cap_l = '0;
		cap_r = '0;
		for (int h = 0; h < 2; h++) begin
			for (int b = 0; b < 32; b++) begin
				i = b - s;
				bclk = p;
				lrclk = (h == 0);
				wstrb = (f == 2'b11) && b >= 3 && b < 8;
				// Toggles before the word catch early capture; zeros after it
				// pad a short word, as the port reads 16 bits unless the channel change comes first
				sdata = (i >= 0 && i < n) ? (h == 1 ? rw[15-i] : lw[15-i]) :
					(i < 0) ? b[0] : 1'b0;
				#200;
				bclk = ~p;
				if (i >= 0 && i < 24) begin
					if (h == 1) cap_r[23-i] = out_data;
					else cap_l[23-i] = out_data;
				end else if (out_data !== 1'b0) begin
					stray++;
				end
				#200;
				if (gap && b == 10) #2000;
			end
		end
	endtask : frame
endmodule : ssap_far_end

`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import ssap_pkg::*;
	logic        mclk, rst_b, bclk, lrclk, wstrb, sdata, pol, sa, sb, mute;
	logic        out_take, out_data, in_valid;
	logic [15:0] in_left, in_right;
	logic [23:0] out_left, out_right, cap_l, cap_r;
	int          stray, bad_count, tests_run, takes, valids, s0;

	ssap_ports dut (.mclk(mclk), .rst_b(rst_b), .in_bit_clock(bclk),
		.in_channel_clock(lrclk), .in_word_strobe(wstrb), .in_data(sdata),
		.in_edge_polarity(pol), .in_format_sel_a(sa), .in_format_sel_b(sb),
		.in_left(in_left), .in_right(in_right), .in_valid(in_valid),
		.out_bit_clock(bclk), .out_channel_clock(lrclk), .out_word_strobe(wstrb),
		.out_edge_polarity(pol), .out_format_sel_a(sa), .out_format_sel_b(sb),
		.mute(mute), .out_left(out_left), .out_right(out_right),
		.out_take(out_take), .out_data(out_data));

	ssap_far_end far (.out_data(out_data), .bclk(bclk), .lrclk(lrclk), .wstrb(wstrb),
		.sdata(sdata), .cap_l(cap_l), .cap_r(cap_r), .stray(stray));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (out_take === 1'b1) takes++;
		if (in_valid === 1'b1) valids++;
	end

	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// Two settling frames, then one checked frame
	// ----------------------------------------
	task automatic run(input logic [1:0] f, input logic p, input int n, input logic m,
		input bit gap);
		logic [15:0] lw;
		logic [15:0] rw;
		logic [23:0] ok;
		lw = 16'hc3a5 & (16'hffff << (16 - n));
		rw = 16'h5e71 & (16'hffff << (16 - n));
		ok = (f == 2'b10) ? 24'hffff00 : 24'hffffff;
		@(negedge mclk);
		pol = p;
		{sa, sb} = f;
		mute = m;
		out_left = 24'h9d3c71 ^ {22'h0, f};
		out_right = 24'h62e58b ^ {23'h0, p};
		takes = 0;
		valids = 0;
		far.frame(f, p, 16'hc3a5, 16'h5e71, n, 1'b0);
		far.frame(f, p, 16'hc3a5, 16'h5e71, n, 1'b0);
		s0 = stray;
		far.frame(f, p, 16'hc3a5, 16'h5e71, n, gap);
		chk("in_left", 24'(lw), 24'(in_left));
		chk("in_right", 24'(rw), 24'(in_right));
		chk("out_left", m ? 24'h0 : out_left & ok, cap_l);
		chk("out_right", m ? 24'h0 : out_right & ok, cap_r);
		chk("stray_ones", 24'h0, 24'(stray - s0));
		chk("out_take", 24'h1, {23'h0, takes != 0});
		chk("in_valid", 24'h1, {23'h0, valids != 0});
	endtask : run

	initial begin
		rst_b = 1'b0;
		pol = 1'b0;
		{sa, sb} = 2'b00;
		mute = 1'b0;
		out_left = '0;
		out_right = '0;
		bad_count = 0;
		tests_run = 0;
		takes = 0;
		valids = 0;
		s0 = 0;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		rst_b = 1'b1;
		for (int f = 0; f < 4; f++) begin
			for (int p = 0; p < 2; p++) begin
				run(2'(f), 1'(p), 4 + 4 * f, 1'b0, 1'b0);
			end
		end
		run(2'b00, 1'b0, 16, 1'b1, 1'b0);
		run(2'b01, 1'b1, 12, 1'b0, 1'b1);
		wrap_up();
	end

	// Ten runs of three frames need about 0.8 ms
	initial begin
		#2000000;
		bad_count++;
		wrap_up();
	end
endmodule : testbench

`default_nettype wire
